/* File: bpa_pkg.sv */
// package: register map, pin assignment fields, reset values and modes
package bpa_pkg;
  // operating modes presented on the mode input
  typedef enum logic [2:0] {
    MODE_SPECIAL_SINGLE = 3'h0,
    MODE_SPECIAL_EXP_NARROW = 3'h1,
    MODE_PERIPHERAL = 3'h2,
    MODE_SPECIAL_EXP_WIDE = 3'h3,
    MODE_NORMAL_SINGLE = 3'h4,
    MODE_NORMAL_EXP_NARROW = 3'h5,
    MODE_NORMAL_EXP_WIDE = 3'h7
  } bpa_mode_e;

  // printed offsets are not all multiples of four: byte address = 4 * index
  localparam logic [7:0] IDX_LOW_DATA = 8'h01;
  localparam logic [7:0] IDX_LOW_DIR = 8'h03;
  localparam logic [7:0] IDX_BC_DATA = 8'h08;
  localparam logic [7:0] IDX_BC_DIR = 8'h09;
  localparam logic [7:0] IDX_ASSIGN = 8'h0A;
  localparam logic [7:0] IDX_MISC = 8'h10;

  // assignment register fields
  localparam int F_NO_DATA_ENABLE = 7;
  localparam int F_CLOCK_TEST_ENABLE = 6;
  localparam int F_PIPE_OUTPUT_ENABLE = 5;
  localparam int F_NO_E_CLOCK = 4;
  localparam int F_LOW_STROBE_ENABLE = 3;
  localparam int F_READ_WRITE_ENABLE = 2;
  localparam int F_CALIBRATION_ENABLE = 1;
  localparam int F_PIN7_SELECT = 0;

  // misc control register fields (port_emulation, pull-up enable)
  localparam int F_PORT_EMULATION = 0;
  localparam int F_PULLUP_ENABLE = 1;

  // assignment register reset values per mode
  localparam logic [7:0] RST_NORMAL_EXP = 8'h00;
  localparam logic [7:0] RST_SPECIAL = 8'h2C;
  localparam logic [7:0] RST_PERIPHERAL = 8'hD0;
  localparam logic [7:0] RST_NORMAL_SINGLE = 8'h90;

  localparam logic [7:0] RST_PORT = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
endpackage

/* File: bpa_sync.sv */
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module bpa_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins and filtered result
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } bpa_sync_s;
  bpa_sync_s r_q;
  bpa_sync_s r_d;

  // a level counts only once the second and third stages agree
  always_comb begin
    r_d = r_q;
    r_d.s1 = pin_in;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (r_q.s2[i] == r_q.s3[i]) begin
        r_d.lvl[i] = r_q.s3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign level_out = r_q.lvl;
endmodule
`default_nettype wire

/* File: bpa_assign_reg.sv */
// write-restricted pin assignment register with first-write tracking
`timescale 1ns/1ps
`default_nettype none
module bpa_assign_reg (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // mode and write port
  input wire logic [2:0] mode,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // register value
  output logic [7:0] value
);
  typedef struct packed {
    logic [7:0] val;
    logic [7:0] written;
    logic loaded;
  } bpa_assign_s;
  bpa_assign_s r_q;
  bpa_assign_s r_d;
  logic special;
  logic [7:0] rst_val;

  assign special = ~mode[2];

  // mode dependent reset value, caught on the first clock after release
  always_comb begin
    case (mode)
      // [RQ11] single-chip reset
      bpa_pkg::MODE_NORMAL_SINGLE: rst_val = bpa_pkg::RST_NORMAL_SINGLE;
      // [RQ12] expanded reset zero
      bpa_pkg::MODE_NORMAL_EXP_NARROW, bpa_pkg::MODE_NORMAL_EXP_WIDE:
        rst_val = bpa_pkg::RST_NORMAL_EXP;
      // [RQ15] clock test set
      bpa_pkg::MODE_PERIPHERAL: rst_val = bpa_pkg::RST_PERIPHERAL;
      // [RQ13] special modes pipes
      default: rst_val = bpa_pkg::RST_SPECIAL;
    endcase
  end

  // per-bit write policy
  always_comb begin
    r_d = r_q;
    if (!r_q.loaded) begin
      r_d.val = rst_val;
      r_d.loaded = 1'b1;
    end else if (wr_en) begin
      for (int i = 0; i < 8; i++) begin
        // [RQ23] first write record
        r_d.written[i] = 1'b1;
        if (i == bpa_pkg::F_CALIBRATION_ENABLE) begin
          r_d.val[i] = wr_data[i];
        end else if (i == bpa_pkg::F_NO_E_CLOCK) begin
          // write once normal single, anytime special single, else never
          if (mode == bpa_pkg::MODE_SPECIAL_SINGLE ||
              (mode == bpa_pkg::MODE_NORMAL_SINGLE && !r_q.written[i])) begin
            r_d.val[i] = wr_data[i];
          end
        end else if (i == bpa_pkg::F_CLOCK_TEST_ENABLE) begin
          // [RQ19] never normal, not first special
          if (special && r_q.written[i]) begin
            r_d.val[i] = wr_data[i];
          end
        end else begin
          // [RQ16] once normal, after first special
          if (special ? r_q.written[i] : !r_q.written[i]) begin
            r_d.val[i] = wr_data[i];
          end
        end
      end
    end
  end

  // reset takes constants only; the mode value loads one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign value = r_q.val;
endmodule
`default_nettype wire

/* File: bpa_top.sv */
// low address/data port and bus-control port with APB register access
//
// Overview of operation
// [RQ1] expanded/peripheral: low port carries address/data; narrow carries address only
// [RQ2] expanded/peripheral: low port data register leaves on-chip map
// [RQ3] expanded/peripheral: low port direction register leaves on-chip map
// [RQ4] direction bit clear is input, set drives output
// [RQ5] bus-control pins offer strobe, clock, mode, pipe, interrupt alternates
// [RQ6] assignment register picks I/O or alternate per pin
// [RQ7] alternate function pins ignore their direction bit
// [RQ8] one bit enables pull-ups on selected pins that are inputs
// [RQ9] bus-control registers absent in peripheral, or expanded with emulation
// [RQ10] pins 1 and 0 are interrupt inputs, never outputs, always readable
// [RQ11] normal single-chip reset: all I/O, no-data-enable and no-E-clock set
// [RQ12] normal expanded reset: zero, only data-enable and E clock active
// [RQ13] special modes reset: pipes, low strobe and read/write enabled
// [RQ14] software writes assignment before accesses needing extra signals
// [RQ15] peripheral: assignment hidden, clock-test enable resets to one
// [RQ16] no-data-enable: once in normal, all but first in special
// [RQ17] no-data-enable clear: pin 7 data-enable/inverted clock, else calibration/I/O
// [RQ18] single-chip and peripheral: pin 7 calibration or I/O only
// [RQ19] clock-test enable: never in normal, after first in special
// [RQ20] clock-test routes test signal to pin 6; pipe enable wins
// [RQ21] pipe enable in expanded drives queue status on pins 6 and 5
// [RQ22] pin-7 select picks data-enable when clear, inverted clock when set
// [RQ23] restricted bits keep a reset-cleared record of prior writes
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module bpa_top (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // operating mode
  input wire logic [2:0] mode,
  // internal bus signals to route onto pins
  input wire logic [7:0] ext_addr_lo,
  input wire logic [7:0] ext_data_lo,
  input wire logic ext_data_drive,
  input wire logic data_enable_out,
  input wire logic bus_e_clock,
  input wire logic low_strobe,
  input wire logic read_write,
  input wire logic pipe_status_hi,
  input wire logic pipe_status_lo,
  input wire logic clock_test_out,
  input wire logic cal_ref,
  // low port pins
  input wire logic [7:0] low_pin_in,
  output logic [7:0] low_pin_out,
  output logic [7:0] low_pin_oe_n,
  output logic [7:0] ext_data_in,
  // bus-control port pins
  input wire logic [7:0] bc_pin_in,
  output logic [7:0] bc_pin_out,
  output logic [7:0] bc_pin_oe_n,
  output logic [7:0] bc_pullup_en,
  // interrupt levels
  output logic irq_level,
  output logic nonmaskable_interrupt_in
);
  typedef struct packed {
    logic [7:0] low_data;
    logic [7:0] low_dir;
    logic [7:0] bc_data;
    logic [7:0] bc_dir;
    logic [1:0] misc;
    logic [31:0] rdata;
  } bpa_top_s;
  bpa_top_s r_q;
  bpa_top_s r_d;

  logic [7:0] low_sync;
  logic [7:0] bc_sync;
  logic [7:0] asg;
  logic [7:0] idx;
  logic addr_ok;
  logic access;
  logic asg_wr;
  logic single;
  logic periph;
  logic expanded;
  logic special;
  logic narrow;
  logic low_hidden;
  logic bc_hidden;
  logic [7:0] bc_alt;
  logic [7:0] bc_alt_val;
  logic [7:0] bc_alt_drv;

  // decode a mode into its class
  function automatic logic is_single(input logic [2:0] m);
    return m == bpa_pkg::MODE_NORMAL_SINGLE ||
           m == bpa_pkg::MODE_SPECIAL_SINGLE;
  endfunction

  assign single = is_single(mode);
  assign periph = (mode == bpa_pkg::MODE_PERIPHERAL);
  assign expanded = !is_single(mode) && !periph;
  assign special = ~mode[2];
  assign narrow = (mode == bpa_pkg::MODE_NORMAL_EXP_NARROW) ||
                  (mode == bpa_pkg::MODE_SPECIAL_EXP_NARROW);

  // pins cross into pclk through the agreement filter
  bpa_sync #(.WIDTH(8)) u_low_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(low_pin_in),
    .level_out(low_sync)
  );
  bpa_sync #(.WIDTH(8)) u_bc_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(bc_pin_in),
    .level_out(bc_sync)
  );

  // apb decode; word index is paddr divided by four
  assign idx = {2'h0, paddr[7:2]};
  assign access = psel && penable;
  assign pready = 1'b1;
  // [RQ2] data hidden when expanded
  // [RQ3] direction hidden too
  assign low_hidden = !single;
  // [RQ9] hidden peripheral or emulation
  assign bc_hidden = periph || (expanded && r_q.misc[bpa_pkg::F_PORT_EMULATION]);

  always_comb begin
    case (idx)
      bpa_pkg::IDX_LOW_DATA, bpa_pkg::IDX_LOW_DIR: addr_ok = !low_hidden;
      bpa_pkg::IDX_BC_DATA, bpa_pkg::IDX_BC_DIR: addr_ok = !bc_hidden;
      // [RQ15] hidden in peripheral
      bpa_pkg::IDX_ASSIGN: addr_ok = !periph;
      bpa_pkg::IDX_MISC: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // hidden registers answer as an error; the external bus would serve them
  assign pslverr = access && !addr_ok;
  assign asg_wr = access && pwrite && addr_ok && (idx == bpa_pkg::IDX_ASSIGN);

  bpa_assign_reg u_assign (
    .pclk(pclk),
    .presetn(presetn),
    .mode(mode),
    .wr_en(asg_wr),
    .wr_data(pwdata[7:0]),
    .value(asg)
  );

  // alternate function selection per bus-control pin
  always_comb begin
    bc_alt = 8'h00;
    bc_alt_val = 8'h00;
    bc_alt_drv = 8'h00;
    // [RQ17] pin 7 from no-data-enable
    // [RQ18] single-chip ignores it
    if (expanded && !asg[bpa_pkg::F_NO_DATA_ENABLE]) begin
      bc_alt[7] = 1'b1;
      bc_alt_drv[7] = 1'b1;
      // [RQ22] data-enable or inverted clock
      bc_alt_val[7] = asg[bpa_pkg::F_PIN7_SELECT] ? ~bus_e_clock :
                      data_enable_out;
    end else if (asg[bpa_pkg::F_CALIBRATION_ENABLE]) begin
      bc_alt[7] = 1'b1;
      bc_alt_drv[7] = 1'b1;
      bc_alt_val[7] = cal_ref;
    end
    // [RQ21] pipe status outputs
    if (expanded && asg[bpa_pkg::F_PIPE_OUTPUT_ENABLE]) begin
      bc_alt[6:5] = 2'h3;
      bc_alt_drv[6:5] = 2'h3;
      bc_alt_val[6:5] = {pipe_status_hi, pipe_status_lo};
    end else if (asg[bpa_pkg::F_CLOCK_TEST_ENABLE] && !single &&
                 !(expanded && !special)) begin
      // [RQ20] clock test on pin 6
      bc_alt[6] = 1'b1;
      bc_alt_drv[6] = 1'b1;
      bc_alt_val[6] = clock_test_out;
    end
    // E clock pin; an input in peripheral mode
    if (!asg[bpa_pkg::F_NO_E_CLOCK]) begin
      bc_alt[4] = 1'b1;
      bc_alt_drv[4] = !periph;
      bc_alt_val[4] = bus_e_clock;
    end
    if (asg[bpa_pkg::F_LOW_STROBE_ENABLE] && !single &&
        mode != bpa_pkg::MODE_NORMAL_EXP_NARROW) begin
      bc_alt[3] = 1'b1;
      bc_alt_drv[3] = 1'b1;
      bc_alt_val[3] = low_strobe;
    end
    if (asg[bpa_pkg::F_READ_WRITE_ENABLE] && !single) begin
      bc_alt[2] = 1'b1;
      bc_alt_drv[2] = 1'b1;
      bc_alt_val[2] = read_write;
    end
    // [RQ5] pins 1 and 0 interrupts
    bc_alt[1:0] = 2'h3;
  end

  // register next state and read data
  always_comb begin
    r_d = r_q;
    if (access && pwrite && addr_ok) begin
      case (idx)
        bpa_pkg::IDX_LOW_DATA: r_d.low_data = pwdata[7:0];
        bpa_pkg::IDX_LOW_DIR: r_d.low_dir = pwdata[7:0];
        bpa_pkg::IDX_BC_DATA: r_d.bc_data = pwdata[7:0];
        bpa_pkg::IDX_BC_DIR: r_d.bc_dir = pwdata[7:0];
        bpa_pkg::IDX_MISC: r_d.misc = pwdata[1:0];
        default: r_d.misc = r_q.misc;
      endcase
    end
    r_d.rdata = bpa_pkg::UNMAPPED_READ;
    if (psel && !penable && !pwrite) begin
      case (idx)
        // inputs read the pin, outputs read the latch
        bpa_pkg::IDX_LOW_DATA:
          r_d.rdata[7:0] = (r_q.low_dir & r_q.low_data) |
                           (~r_q.low_dir & low_sync);
        bpa_pkg::IDX_LOW_DIR: r_d.rdata[7:0] = r_q.low_dir;
        // [RQ10] interrupt pins always readable
        bpa_pkg::IDX_BC_DATA:
          r_d.rdata[7:0] = (r_q.bc_dir & ~bc_alt & r_q.bc_data) |
                           (~(r_q.bc_dir & ~bc_alt) & bc_sync);
        bpa_pkg::IDX_BC_DIR: r_d.rdata[7:0] = r_q.bc_dir;
        bpa_pkg::IDX_ASSIGN: r_d.rdata[7:0] = asg;
        bpa_pkg::IDX_MISC: r_d.rdata[1:0] = r_q.misc;
        default: r_d.rdata = bpa_pkg::UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // read data captured in setup, presented through the access phase
  assign prdata = r_q.rdata;

  // low port pin drivers
  always_comb begin
    ext_data_in = low_sync;
    if (!single) begin
      // [RQ1] address/data on low port
      low_pin_out = (narrow || !ext_data_drive) ? ext_addr_lo : ext_data_lo;
      low_pin_oe_n = (narrow || periph) ? 8'h00 :
                     (ext_data_drive ? 8'h00 : 8'hFF);
    end else begin
      // [RQ4] direction bit sets drive
      low_pin_out = r_q.low_data;
      low_pin_oe_n = ~r_q.low_dir;
    end
  end

  // bus-control port pin drivers
  always_comb begin
    // [RQ6] per-pin select
    // [RQ7] alternate ignores direction
    bc_pin_out = (bc_alt & bc_alt_val) | (~bc_alt & r_q.bc_data);
    bc_pin_oe_n = ~((bc_alt & bc_alt_drv) | (~bc_alt & r_q.bc_dir));
    // [RQ10] never outputs
    bc_pin_oe_n[1:0] = 2'h3;
    bc_pin_out[1:0] = 2'h0;
    // [RQ8] pull-ups on inputs
    bc_pullup_en = {8{r_q.misc[bpa_pkg::F_PULLUP_ENABLE]}} & 8'h8F &
                   bc_pin_oe_n;
  end

  assign irq_level = bc_sync[1];
  assign nonmaskable_interrupt_in = bc_sync[0];
endmodule
`default_nettype wire

/* File: bpa_checker.sv */
// checker: port-level relations of the bus port block
`timescale 1ns/1ps
`default_nettype none
module bpa_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  // mode and alternate sources
  input wire logic [2:0] mode,
  input wire logic [7:0] ext_addr_lo,
  input wire logic bus_e_clock,
  input wire logic clock_test_out,
  // pins
  input wire logic [7:0] low_pin_out,
  input wire logic [7:0] low_pin_oe_n,
  input wire logic [7:0] bc_pin_in,
  input wire logic [7:0] bc_pin_out,
  input wire logic [7:0] bc_pin_oe_n,
  input wire logic [7:0] bc_pullup_en,
  input wire logic irq_level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access phase, and modes that use the external bus
  wire logic acc = psel && penable;
  wire logic ext = (mode != 3'h0) && (mode != 3'h4);
  a_low_hidden: assert property (
    acc && ext && paddr inside {8'h04, 8'h0C} |-> pslverr)
    else $error("low port register visible on external bus");
  a_bc_hidden: assert property (
    acc && mode == 3'h2 && paddr inside {8'h20, 8'h24} |-> pslverr)
    else $error("bus-control register visible in peripheral mode");
  a_assign_hidden: assert property (
    acc && mode == 3'h2 && paddr == 8'h28 |-> pslverr)
    else $error("assignment register visible in peripheral mode");
  a_irq_input: assert property (bc_pin_oe_n[1:0] == 2'h3)
    else $error("interrupt pin driven");
  a_irq_level: assert property (
    $stable(bc_pin_in[1]) [*8] |-> irq_level == bc_pin_in[1])
    else $error("interrupt level not readable");
  a_narrow_addr: assert property (
    mode inside {3'h1, 3'h5} |->
    low_pin_oe_n == 8'h00 && low_pin_out == ext_addr_lo)
    else $error("narrow mode low port not address");
  a_pull_inputs: assert property (
    (bc_pullup_en & ~bc_pin_oe_n) == 8'h00 && bc_pullup_en[6:4] == 3'h0)
    else $error("pull-up on output or unsupported pin");
  a_bus_e_clock_pin: assert property (
    mode[0] |-> !bc_pin_oe_n[4] && bc_pin_out[4] == bus_e_clock)
    else $error("E clock missing in expanded mode");
  // assignment value lands one edge after release
  a_test_pin: assert property (
    mode == 3'h2 && $past(presetn) |->
    !bc_pin_oe_n[6] && bc_pin_out[6] == clock_test_out)
    else $error("clock test output missing in peripheral mode");
endmodule
`default_nettype wire

/* File: bpa_pin_partner.sv */
// far-side pin model: resolves the level seen on each pin
`timescale 1ns/1ps
`default_nettype none
module bpa_pin_partner (
  // clock
  input wire logic pclk,
  // pins driven by the block
  input wire logic [7:0] low_pin_out,
  input wire logic [7:0] low_pin_oe_n,
  input wire logic [7:0] bc_pin_out,
  input wire logic [7:0] bc_pin_oe_n,
  input wire logic [7:0] bc_pullup_en,
  // external interrupt sources, wire level
  input wire logic [1:0] irq_src,
  // resolved levels
  output logic [7:0] low_pin_in,
  output logic [7:0] bc_pin_in
);
  logic [7:0] churn_q = 8'h00;
  // undriven lines wander so a stale value never passes for data
  always @(posedge pclk) begin
    churn_q <= churn_q + 8'h01;
  end
  // released pins float or follow pull-ups
  always_comb begin
    low_pin_in = (~low_pin_oe_n & low_pin_out) | (low_pin_oe_n & churn_q);
    bc_pin_in = (~bc_pin_oe_n & bc_pin_out) |
                (bc_pin_oe_n & (bc_pullup_en | churn_q));
    bc_pin_in[1:0] = irq_src;
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// testbench: register map, reset values and pin routing
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ext_data_drive = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] mode = 3'h4;
  logic [2:0] src_q = 3'h0;
  logic [1:0] irq_src = 2'h3;
  logic low_strobe = 1'b1, read_write = 1'b0, cal_ref = 1'b1;
  logic pipe_status_hi = 1'b1, pipe_status_lo = 1'b0;
  wire logic bus_e_clock = src_q[0];
  wire logic data_enable_out = src_q[1];
  wire logic clock_test_out = src_q[2];
  wire logic [7:0] ext_addr_lo = {5'h1A, src_q};
  wire logic [7:0] ext_data_lo = ~ext_addr_lo;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, irq_level, nonmaskable_interrupt_in;
  wire logic [7:0] low_pin_in, low_pin_out, low_pin_oe_n, bc_pin_in;
  wire logic [7:0] bc_pin_out, bc_pin_oe_n, bc_pullup_en;
  int fail_count = 0;
  int n_compared = 0;
  // clock, and alternate sources that keep moving
  always #25 pclk = ~pclk;
  always @(posedge pclk) src_q <= src_q + 3'h1;
  bpa_top bpa_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode(mode),
    .ext_addr_lo(ext_addr_lo), .ext_data_lo(ext_data_lo),
    .ext_data_drive(ext_data_drive), .data_enable_out(data_enable_out),
    .bus_e_clock(bus_e_clock), .low_strobe(low_strobe),
    .read_write(read_write), .pipe_status_hi(pipe_status_hi),
    .pipe_status_lo(pipe_status_lo), .clock_test_out(clock_test_out),
    .cal_ref(cal_ref), .low_pin_in(low_pin_in), .low_pin_out(low_pin_out),
    .low_pin_oe_n(low_pin_oe_n), .ext_data_in(), .bc_pin_in(bc_pin_in),
    .bc_pin_out(bc_pin_out), .bc_pin_oe_n(bc_pin_oe_n),
    .bc_pullup_en(bc_pullup_en), .irq_level(irq_level),
    .nonmaskable_interrupt_in(nonmaskable_interrupt_in));
  bpa_pin_partner bpa_pin_partner_i (.pclk(pclk), .low_pin_out(low_pin_out),
    .low_pin_oe_n(low_pin_oe_n), .bc_pin_out(bc_pin_out),
    .bc_pin_oe_n(bc_pin_oe_n), .bc_pullup_en(bc_pullup_en),
    .irq_src(irq_src), .low_pin_in(low_pin_in), .bc_pin_in(bc_pin_in));

  task automatic chk(input string n, input logic [7:0] g, e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, d,
                     output logic [7:0] q, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    logic er;
    apb(1'b1, a, d, q, er);
  endtask
  task automatic rdchk(input logic [7:0] a, e);
    logic [7:0] q;
    logic er;
    apb(1'b0, a, 8'h00, q, er);
    chk("rdata", q, e);
    chk("rd_err", {7'h0, er}, 8'h00);
  endtask
  task automatic errchk(input logic [7:0] a);
    logic [7:0] q;
    logic er;
    apb(1'b0, a, 8'h00, q, er);
    chk("hidden_err", {7'h0, er}, 8'h01);
  endtask
  // drive and enable of one bus-control pin, read after outputs settle
  // source picked at the sampling time, since the sources move every rising edge
  task automatic pin(input string n, input int i, input int s);
    logic e;
    @(negedge pclk);
    case (s)
      0: e = cal_ref;
      1: e = data_enable_out;
      2: e = ~bus_e_clock;
      3: e = pipe_status_hi;
      default: e = clock_test_out;
    endcase
    chk(n, {6'h0, bc_pin_oe_n[i], bc_pin_out[i]}, {7'h0, e});
  endtask
  task automatic rst(input logic [2:0] m);
    presetn <= 1'b0;
    mode <= m;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask

  task automatic t_reset_vals();
    logic [2:0] ms [6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h7};
    logic [7:0] ev [6] = '{8'h2C, 8'h2C, 8'h2C, 8'h90, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rst(ms[i]);
      rdchk(8'h28, ev[i]);
    end
  endtask
  task automatic t_hidden();
    rst(3'h2);
    errchk(8'h04);
    errchk(8'h0C);
    errchk(8'h20);
    errchk(8'h24);
    errchk(8'h28);
    rst(3'h7);
    errchk(8'h0C);
    rdchk(8'h24, 8'h00);
    wr(8'h40, 8'h01);
    errchk(8'h20);
    errchk(8'h44);
  endtask
  task automatic t_gpio();
    rst(3'h4);
    wr(8'h0C, 8'hF0);
    wr(8'h04, 8'hA5);
    wr(8'h24, 8'hFF);
    wr(8'h20, 8'h5A);
    @(negedge pclk);
    chk("low_oe", low_pin_oe_n, 8'h0F);
    chk("low_out", low_pin_out & 8'hF0, 8'hA0);
    chk("bc_oe", bc_pin_oe_n, 8'h03);
    chk("bc_out", bc_pin_out & 8'hFC, 8'h58);
    wr(8'h40, 8'h02);
    wr(8'h24, 8'h00);
    @(negedge pclk);
    chk("pull_in", bc_pullup_en, 8'h8F);
    wr(8'h24, 8'hFF);
    @(negedge pclk);
    chk("pull_out", bc_pullup_en, 8'h03);
    wr(8'h28, 8'h92);
    rdchk(8'h28, 8'h92);
    pin("p7_cal", 7, 0);
    irq_src <= 2'h1;
    repeat (8) @(posedge pclk);
    chk("irq", {6'h0, irq_level, nonmaskable_interrupt_in}, 8'h01);
  endtask
  task automatic t_normal_exp();
    rst(3'h7);
    wr(8'h24, 8'h00);
    pin("p7_dbe", 7, 1);
    chk("low_addr", low_pin_out, ext_addr_lo);
    @(posedge pclk);
    ext_data_drive <= 1'b1;
    @(negedge pclk);
    chk("low_data", low_pin_out, ext_data_lo);
    @(posedge pclk);
    ext_data_drive <= 1'b0;
    wr(8'h28, 8'hFF);
    rdchk(8'h28, 8'hAF);
    @(negedge pclk);
    chk("alt_oe", bc_pin_oe_n & 8'hEC, 8'h00);
    chk("alt_out", bc_pin_out & 8'hEC, 8'hC8);
    wr(8'h28, 8'h00);
    rdchk(8'h28, 8'hAD);
  endtask
  task automatic t_special();
    rst(3'h3);
    wr(8'h28, 8'hFF);
    rdchk(8'h28, 8'h2E);
    wr(8'h28, 8'hFF);
    rdchk(8'h28, 8'hEF);
    pin("p6_pipe", 6, 3);
    wr(8'h28, 8'h41);
    pin("p6_test", 6, 4);
    pin("p7_inv", 7, 2);
    wr(8'h28, 8'h40);
    pin("p7_de", 7, 1);
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    t_reset_vals();
    t_hidden();
    t_gpio();
    t_normal_exp();
    t_special();
    print_verdict();
  end
  // watchdog well beyond the two hundred or so cycles needed
  initial begin
    #2000000;
    fail_count++;
    print_verdict();
  end
endmodule
bind bpa_top bpa_checker bpa_checker_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .mode(mode), .ext_addr_lo(ext_addr_lo), .bus_e_clock(bus_e_clock),
  .clock_test_out(clock_test_out), .low_pin_out(low_pin_out),
  .low_pin_oe_n(low_pin_oe_n), .bc_pin_in(bc_pin_in),
  .bc_pin_out(bc_pin_out), .bc_pin_oe_n(bc_pin_oe_n),
  .bc_pullup_en(bc_pullup_en), .irq_level(irq_level));
`default_nettype wire
